// ===== fault_reporter_pkg.sv
// Package with register map, timing, states and detector bundle for the fault reporter
package fault_reporter_pkg;
    localparam int NUM_CH = 12;
    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CH_EN   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DIAG_EN = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_MASK    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_FLAGS   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_OPEN    = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_SHORT   = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_DIAG    = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ST  = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MSK = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_STATE   = 8'h28;

    // Control register bits
    localparam int CB_FAULT_CLR = 0;
    localparam int CB_POR_CLR   = 1;
    localparam int CB_FS_CLR    = 2;
    localparam int CB_INV_START = 3;
    localparam int CB_SS_START  = 4;
    localparam int CB_AUTO_SS   = 5;

    // Mask register bits
    localparam int MB_REF   = 0;
    localparam int MB_OPEN  = 1;
    localparam int MB_SHORT = 2;
    localparam int MB_TSD   = 3;
    localparam int MB_CRC   = 4;

    // Event bits, shared by flag and interrupt registers
    localparam int EV_POR    = 0;
    localparam int EV_LOWSUP = 1;
    localparam int EV_REF    = 2;
    localparam int EV_PRETSD = 3;
    localparam int EV_TSD    = 4;
    localparam int EV_FS     = 5;
    localparam int EV_OPEN   = 6;
    localparam int EV_SHORT  = 7;
    localparam int EV_DIAG   = 8;
    localparam int EV_CRC    = 9;
    localparam int EV_ODRDY  = 10;
    localparam int EV_N      = 11;
    // Flag register summary bits
    localparam int FB_OUT = 11;
    localparam int FB_ERR = 12;

    localparam logic [NUM_CH-1:0] CH_EN_RST   = 12'hFFF;
    localparam logic [NUM_CH-1:0] DIAG_EN_RST = 12'hFFF;

    localparam int PULSE_US  = 50;
    localparam int CLK_MHZ   = 10;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam int PCNT_W    = 10;

    typedef enum logic [3:0] {
        ST_POR      = 4'b0001,
        ST_INIT     = 4'b0010,
        ST_NORMAL   = 4'b0100,
        ST_FAILSAFE = 4'b1000
    } dev_state_e;

    typedef struct packed {
        logic              supply_uvlo;
        logic              rails_good;
        logic              low_supply;
        logic              ref_fault;
        logic              pre_tsd;
        logic              tsd;
        logic              temp_ok;
        logic              wd_overflow;
        logic [NUM_CH-1:0] open_det;
        logic [NUM_CH-1:0] open_window_ok;
        logic [NUM_CH-1:0] short_det;
        logic              inv_done;
        logic [NUM_CH-1:0] inv_fail;
        logic              ss_done;
        logic [NUM_CH-1:0] ss_below;
        logic              auto_valid;
        logic [NUM_CH-1:0] auto_below;
        logic              crc_valid;
        logic [7:0]        computed_nvm_checksum;
        logic [7:0]        stored_nvm_checksum;
    } detect_s;
endpackage

// ===== normal_state_fault_reporter.sv
// Fault collection, error line and APB register file of the LED driver in normal state
// Operation
// - Undervoltage forces power-on state, sets power-on and error flags, error line held low.
// - Leave power-on state for init only when every rail is good.
// - Power-on flag cleared only by its own clear command, not the general one.
// - Low supply sets flags, pulses error line 50 us, suppresses supply-dependent faults.
// - Thermal shutdown turns channels off, sets flags, holds error line unless masked.
// - Outputs return when temperature ok; thermal flag stays until general clear.
// - Watchdog overflow enters fail-safe, sets flag silently; leave only on fail-safe clear or undervoltage.
// - Checksum mismatch sets flags and pulses error line unless masked.
// - Open fault only on enabled, diagnosed channels with long enough on-pulse.
// - Invisible scan tests disabled diagnosed channels; sets ready, result, summary, pulses line.
// - Short scan tests disabled diagnosed channels; fault only when supply is high.
// - Auto short scan on enabled diagnosed channels; fault sets flags and pulses once.
// - General fault clear bit returns to zero by itself.
// - Short scan start bit drops back to zero the next cycle.
// - Ready flag cleared at scan start, set when scan finishes.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module normal_state_fault_reporter (
    input  wire logic                                    pclk,
    input  wire logic                                    presetn,
    input  wire logic                                    psel,
    input  wire logic                                    penable,
    input  wire logic                                    pwrite,
    input  wire logic [fault_reporter_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                             pwdata,
    output logic      [31:0]                             prdata,
    output logic                                         pready,
    output logic                                         pslverr,
    input  wire fault_reporter_pkg::detect_s             det,
    output logic                                         err_out,
    output logic                                         err_oe,
    output logic      [fault_reporter_pkg::NUM_CH-1:0]   channel_drive,
    output logic                                         inv_scan_go,
    output logic                                         ss_scan_go,
    output logic      [fault_reporter_pkg::NUM_CH-1:0]   scan_channels,
    output logic                                         irq
);
    localparam int N = fault_reporter_pkg::NUM_CH;

    fault_reporter_pkg::dev_state_e state_r;
    logic [5:0]                     cmd_r;
    logic [N-1:0]                   ch_en_r;
    logic [N-1:0]                   diag_en_r;
    logic [4:0]                     mask_r;
    logic [fault_reporter_pkg::EV_N-1:0] flag_r;
    logic [N-1:0]                   open_r;
    logic [N-1:0]                   short_r;
    logic [N-1:0]                   diag_r;
    logic [fault_reporter_pkg::EV_N-1:0] irq_st_r;
    logic [fault_reporter_pkg::EV_N-1:0] irq_msk_r;
    logic                           tsd_active_r;
    logic                           inv_busy_r;
    logic                           ss_busy_r;
    logic [fault_reporter_pkg::PCNT_W-1:0] pulse_cnt_r;
    logic                           err_flag_r;

    logic wr;
    logic fault_clr;
    logic [N-1:0] open_set;
    logic [N-1:0] short_set;
    logic [N-1:0] diag_set;
    logic [fault_reporter_pkg::EV_N-1:0] ev;
    logic out_sum;
    logic crc_bad;
    logic pulse_ev;
    logic hold_low;

    assign wr        = psel & penable & pwrite;
    assign pready    = 1'b1;
    assign fault_clr = cmd_r[fault_reporter_pkg::CB_FAULT_CLR];

    // Command bits 0-4 live one cycle only; the auto-scan bit 5 stays until rewritten
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_r <= 6'h00;
        end else begin
            cmd_r[4:0] <= 5'h00;
            if (wr && paddr == fault_reporter_pkg::OFS_CTRL) begin
                cmd_r <= pwdata[5:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch_en_r   <= fault_reporter_pkg::CH_EN_RST;
            diag_en_r <= fault_reporter_pkg::DIAG_EN_RST;
            mask_r    <= 5'h00;
            irq_msk_r <= 11'h000;
        end else if (wr) begin
            case (paddr)
                fault_reporter_pkg::OFS_CH_EN:   ch_en_r   <= pwdata[N-1:0];
                fault_reporter_pkg::OFS_DIAG_EN: diag_en_r <= pwdata[N-1:0];
                fault_reporter_pkg::OFS_MASK:    mask_r    <= pwdata[4:0];
                fault_reporter_pkg::OFS_IRQ_MSK: irq_msk_r <= pwdata[10:0];
                default: ;
            endcase
        end
    end

    // Device state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= fault_reporter_pkg::ST_POR;
        end else if (det.supply_uvlo) begin
            state_r <= fault_reporter_pkg::ST_POR;
        end else begin
            case (state_r)
                fault_reporter_pkg::ST_POR:
                    if (det.rails_good) state_r <= fault_reporter_pkg::ST_INIT;
                fault_reporter_pkg::ST_INIT:
                    state_r <= fault_reporter_pkg::ST_NORMAL;
                fault_reporter_pkg::ST_NORMAL:
                    if (det.wd_overflow) state_r <= fault_reporter_pkg::ST_FAILSAFE;
                fault_reporter_pkg::ST_FAILSAFE:
                    if (cmd_r[fault_reporter_pkg::CB_FS_CLR]) begin
                        state_r <= fault_reporter_pkg::ST_NORMAL;
                    end
                default:
                    state_r <= fault_reporter_pkg::ST_POR;
            endcase
        end
    end

    // Channel gating and event qualification; low supply hides supply-dependent faults
    assign crc_bad = det.crc_valid &&
                     det.computed_nvm_checksum != det.stored_nvm_checksum;
    always_comb begin
        open_set  = det.open_det & det.open_window_ok & ch_en_r & diag_en_r
                    & {N{~det.low_supply}};
        short_set = det.short_det & ch_en_r & diag_en_r;
        diag_set  = '0;
        if (inv_busy_r && det.inv_done) begin
            diag_set = diag_set | (det.inv_fail & scan_channels);
        end
        if (ss_busy_r && det.ss_done && !det.low_supply) begin
            diag_set = diag_set | (det.ss_below & scan_channels);
        end
        if (cmd_r[fault_reporter_pkg::CB_AUTO_SS] && det.auto_valid && !det.low_supply) begin
            diag_set = diag_set | (det.auto_below & ch_en_r & diag_en_r);
        end
        ev = '0;
        ev[fault_reporter_pkg::EV_POR]    = det.supply_uvlo;
        ev[fault_reporter_pkg::EV_LOWSUP] = det.low_supply;
        ev[fault_reporter_pkg::EV_REF]    = det.ref_fault;
        ev[fault_reporter_pkg::EV_PRETSD] = det.pre_tsd;
        ev[fault_reporter_pkg::EV_TSD]    = det.tsd;
        ev[fault_reporter_pkg::EV_FS]     = det.wd_overflow
                                            && state_r == fault_reporter_pkg::ST_NORMAL;
        ev[fault_reporter_pkg::EV_OPEN]   = |open_set;
        ev[fault_reporter_pkg::EV_SHORT]  = |short_set;
        ev[fault_reporter_pkg::EV_DIAG]   = |diag_set;
        ev[fault_reporter_pkg::EV_CRC]    = crc_bad;
        ev[fault_reporter_pkg::EV_ODRDY]  = (inv_busy_r && det.inv_done)
                                            || (ss_busy_r && det.ss_done);
    end

    // Sticky flags: a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r  <= 11'h001;
            open_r  <= '0;
            short_r <= '0;
            diag_r  <= '0;
        end else begin
            flag_r[fault_reporter_pkg::EV_POR] <= ev[fault_reporter_pkg::EV_POR]
                | (flag_r[fault_reporter_pkg::EV_POR]
                   & ~cmd_r[fault_reporter_pkg::CB_POR_CLR]);
            flag_r[fault_reporter_pkg::EV_FS] <= ev[fault_reporter_pkg::EV_FS]
                | (flag_r[fault_reporter_pkg::EV_FS]
                   & ~cmd_r[fault_reporter_pkg::CB_FS_CLR]);
            for (int i = 1; i < fault_reporter_pkg::EV_ODRDY; i++) begin
                if (i != fault_reporter_pkg::EV_FS) begin
                    flag_r[i] <= ev[i] | (flag_r[i] & ~fault_clr);
                end
            end
            if (ev[fault_reporter_pkg::EV_ODRDY]) begin
                flag_r[fault_reporter_pkg::EV_ODRDY] <= 1'b1;
            end else if (inv_scan_go || ss_scan_go) begin
                flag_r[fault_reporter_pkg::EV_ODRDY] <= 1'b0;
            end
            open_r  <= open_set  | (open_r  & {N{~fault_clr}});
            short_r <= short_set | (short_r & {N{~fault_clr}});
            diag_r  <= diag_set  | (diag_r  & {N{~fault_clr}});
        end
    end

    assign out_sum = (|open_r & ~mask_r[fault_reporter_pkg::MB_OPEN])
                   | (|short_r & ~mask_r[fault_reporter_pkg::MB_SHORT]) | (|diag_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_flag_r <= 1'b1;
        end else begin
            err_flag_r <= flag_r[fault_reporter_pkg::EV_POR]
                | flag_r[fault_reporter_pkg::EV_LOWSUP]
                | (flag_r[fault_reporter_pkg::EV_REF] & ~mask_r[fault_reporter_pkg::MB_REF])
                | (flag_r[fault_reporter_pkg::EV_TSD] & ~mask_r[fault_reporter_pkg::MB_TSD])
                | (flag_r[fault_reporter_pkg::EV_CRC] & ~mask_r[fault_reporter_pkg::MB_CRC])
                | out_sum;
        end
    end

    // On-demand scans capture the disabled but diagnosed channels at start
    assign inv_scan_go = cmd_r[fault_reporter_pkg::CB_INV_START] && !inv_busy_r && !ss_busy_r;
    assign ss_scan_go  = cmd_r[fault_reporter_pkg::CB_SS_START] && !inv_busy_r && !ss_busy_r
                         && !cmd_r[fault_reporter_pkg::CB_INV_START];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inv_busy_r    <= 1'b0;
            ss_busy_r     <= 1'b0;
            scan_channels <= '0;
        end else begin
            if (inv_scan_go || ss_scan_go) begin
                scan_channels <= ~ch_en_r & diag_en_r;
            end
            inv_busy_r <= inv_scan_go | (inv_busy_r & ~det.inv_done);
            ss_busy_r  <= ss_scan_go | (ss_busy_r & ~det.ss_done);
        end
    end

    // Thermal shutdown recovers by itself on temperature ok
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tsd_active_r  <= 1'b0;
            channel_drive <= '0;
        end else begin
            if (det.tsd) begin
                tsd_active_r <= 1'b1;
            end else if (det.temp_ok) begin
                tsd_active_r <= 1'b0;
            end
            if (det.tsd || det.supply_uvlo || tsd_active_r
                || state_r == fault_reporter_pkg::ST_POR
                || state_r == fault_reporter_pkg::ST_INIT) begin
                channel_drive <= '0;
            end else begin
                channel_drive <= ch_en_r;
            end
        end
    end

    // One pulse per new low-supply, pre-TSD, checksum, open, short or diag event; fail-safe never touches the line
    assign pulse_ev = (ev[fault_reporter_pkg::EV_LOWSUP] & ~flag_r[fault_reporter_pkg::EV_LOWSUP])
        | (ev[fault_reporter_pkg::EV_PRETSD] & ~flag_r[fault_reporter_pkg::EV_PRETSD])
        | (crc_bad & ~flag_r[fault_reporter_pkg::EV_CRC] & ~mask_r[fault_reporter_pkg::MB_CRC])
        | (|(open_set & ~open_r) & ~mask_r[fault_reporter_pkg::MB_OPEN])
        | (|(short_set & ~short_r) & ~mask_r[fault_reporter_pkg::MB_SHORT])
        | (|(diag_set & ~diag_r));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_cnt_r <= '0;
        end else if (pulse_ev) begin
            pulse_cnt_r <= fault_reporter_pkg::PCNT_W'(fault_reporter_pkg::PULSE_CYC);
        end else if (pulse_cnt_r != '0) begin
            pulse_cnt_r <= pulse_cnt_r - 1'b1;
        end
    end

    assign hold_low = state_r == fault_reporter_pkg::ST_POR
        || (det.ref_fault && !mask_r[fault_reporter_pkg::MB_REF])
        || (tsd_active_r && !mask_r[fault_reporter_pkg::MB_TSD]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_oe <= 1'b1;
        end else begin
            err_oe <= hold_low || pulse_ev || pulse_cnt_r > 1;
        end
    end
    assign err_out = 1'b0;

    // Interrupt status, write one to clear; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_r <= '0;
        end else if (wr && paddr == fault_reporter_pkg::OFS_IRQ_ST) begin
            irq_st_r <= ev | (irq_st_r & ~pwdata[10:0]);
        end else begin
            irq_st_r <= ev | irq_st_r;
        end
    end
    assign irq = |(irq_st_r & irq_msk_r);

    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            fault_reporter_pkg::OFS_CTRL:    prdata[5:0]   = cmd_r;
            fault_reporter_pkg::OFS_CH_EN:   prdata[N-1:0] = ch_en_r;
            fault_reporter_pkg::OFS_DIAG_EN: prdata[N-1:0] = diag_en_r;
            fault_reporter_pkg::OFS_MASK:    prdata[4:0]   = mask_r;
            fault_reporter_pkg::OFS_FLAGS:   prdata[12:0]  = {err_flag_r, out_sum, flag_r};
            fault_reporter_pkg::OFS_OPEN:    prdata[N-1:0] = open_r;
            fault_reporter_pkg::OFS_SHORT:   prdata[N-1:0] = short_r;
            fault_reporter_pkg::OFS_DIAG:    prdata[N-1:0] = diag_r;
            fault_reporter_pkg::OFS_IRQ_ST:  prdata[10:0]  = irq_st_r;
            fault_reporter_pkg::OFS_IRQ_MSK: prdata[10:0]  = irq_msk_r;
            fault_reporter_pkg::OFS_STATE:   prdata[3:0]   = state_r;
            default:                         pslverr       = psel & penable;
        endcase
    end

    chk_uv_por_entry: assert property (@(posedge pclk) disable iff (!presetn)
        det.supply_uvlo |=> state_r == fault_reporter_pkg::ST_POR
            && flag_r[fault_reporter_pkg::EV_POR] ##1 err_oe && err_flag_r)
        else $error("undervoltage did not force power-on state");
    chk_por_exit_gate: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == fault_reporter_pkg::ST_POR && !det.rails_good
            |=> state_r == fault_reporter_pkg::ST_POR)
        else $error("left power-on state without good rails");
    chk_por_flag_keep: assert property (@(posedge pclk) disable iff (!presetn)
        flag_r[fault_reporter_pkg::EV_POR] && !cmd_r[fault_reporter_pkg::CB_POR_CLR]
            |=> flag_r[fault_reporter_pkg::EV_POR])
        else $error("power-on flag lost without its clear");
    chk_pulse_len: assert property (@(posedge pclk) disable iff (!presetn)
        pulse_ev |=> pulse_cnt_r == fault_reporter_pkg::PCNT_W'(fault_reporter_pkg::PULSE_CYC)
            && err_oe)
        else $error("error pulse not started at full length");
    chk_tsd_off: assert property (@(posedge pclk) disable iff (!presetn)
        det.tsd |=> channel_drive == '0 && flag_r[fault_reporter_pkg::EV_TSD]
            ##1 (err_oe || $past(mask_r[fault_reporter_pkg::MB_TSD])))
        else $error("thermal shutdown not applied");
    chk_tsd_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
        flag_r[fault_reporter_pkg::EV_TSD] && !fault_clr |=> flag_r[fault_reporter_pkg::EV_TSD])
        else $error("thermal flag lost without clear");
    chk_fs_stay: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == fault_reporter_pkg::ST_FAILSAFE && !cmd_r[fault_reporter_pkg::CB_FS_CLR]
            && !det.supply_uvlo |=> state_r == fault_reporter_pkg::ST_FAILSAFE)
        else $error("fail-safe left without clear");
    chk_open_qual: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> ((open_r & ~$past(open_r))
            & ~$past(ch_en_r & diag_en_r & det.open_window_ok)) == '0)
        else $error("open fault on unqualified channel");
    chk_start_drop: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_r[fault_reporter_pkg::CB_SS_START] || fault_clr
            |=> !cmd_r[fault_reporter_pkg::CB_SS_START] && !fault_clr)
        else $error("command bit did not drop");
    chk_ready_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        inv_scan_go |=> !flag_r[fault_reporter_pkg::EV_ODRDY] && inv_busy_r)
        else $error("ready flag not cleared at scan start");
endmodule
`default_nettype wire

// ===== err_line_watch.sv
// Master-side watcher of the open-drain error line
`timescale 1ns/1ps
`default_nettype none
module err_line_watch (
    input  wire logic        pclk,
    input  wire logic        err_out,
    input  wire logic        err_oe,
    output logic             err_n,
    output logic [15:0]      last_len
);
    logic [15:0] run = 16'h0000;
    // Pull-up brings the released line high, never a stale value
    assign err_n = err_oe ? err_out : 1'b1;
    always @(posedge pclk) begin
        run <= err_n ? 16'h0000 : run + 16'h0001;
        if (err_n && run != 16'h0000)
            last_len <= run;
    end
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the fault reporter over APB
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready, pslverr, err_out, err_oe, inv_scan_go, ss_scan_go, irq, err_n, se;
    logic [11:0] channel_drive, scan_channels;
    logic [15:0] last_len;
    fault_reporter_pkg::detect_s det = '0;
    int          n_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;
    always #50 pclk = ~pclk;
    normal_state_fault_reporter normal_state_fault_reporter_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .det(det), .err_out(err_out),
        .err_oe(err_oe), .channel_drive(channel_drive), .inv_scan_go(inv_scan_go),
        .ss_scan_go(ss_scan_go), .scan_channels(scan_channels), .irq(irq));
    err_line_watch err_line_watch_inst (.pclk(pclk), .err_out(err_out), .err_oe(err_oe),
        .err_n(err_n), .last_len(last_len));
    task automatic give_verdict;
        if (n_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            give_verdict;
        end
    end
    initial begin
        det.rails_good = 1'b1;
        det.temp_ok = 1'b1;
        tick(2);
        chk(err_oe, 1'b1);
        tick(3);
        presetn <= 1'b1;
        tick(4);
        rdc(8'h28, 32'h4);
        rdc(8'h10, 32'h1001);
        apb(1'b1, 8'h00, 32'h1);
        rdc(8'h10, 32'h1001);
        rdc(8'h00, 32'h0);
        apb(1'b1, 8'h00, 32'h2);
        rdc(8'h10, 32'h0);
        apb(1'b1, 8'h20, 32'h7FF);
        // Checksum mismatch lands mid-pulse, so the pulse restarts
        det.low_supply <= 1'b1;
        tick(1);
        det.low_supply <= 1'b0;
        tick(250);
        det.computed_nvm_checksum <= 8'h5A;
        det.crc_valid <= 1'b1;
        tick(1);
        det.crc_valid <= 1'b0;
        tick(560);
        chk(32'(last_len > 16'd747 && last_len < 16'd756), 32'h1);
        rdc(8'h10, 32'h1202);
        chk(irq, 1'b0);
        apb(1'b1, 8'h24, 32'h7FF);
        tick(1);
        chk(irq, 1'b1);
        apb(1'b1, 8'h20, 32'h7FF);
        tick(1);
        chk(irq, 1'b0);
        apb(1'b1, 8'h00, 32'h1);
        rdc(8'h10, 32'h0);
        apb(1'b1, 8'h0C, 32'h10);
        det.crc_valid <= 1'b1;
        tick(1);
        det.crc_valid <= 1'b0;
        tick(3);
        chk(err_n, 1'b1);
        rdc(8'h10, 32'h200);
        det.tsd <= 1'b1;
        det.temp_ok <= 1'b0;
        tick(3);
        chk(channel_drive, 12'h000);
        chk(err_oe, 1'b1);
        det.tsd <= 1'b0;
        det.temp_ok <= 1'b1;
        tick(3);
        chk(channel_drive, 12'hFFF);
        rdc(8'h10, 32'h1210);
        apb(1'b1, 8'h00, 32'h1);
        tick(520);
        det.wd_overflow <= 1'b1;
        tick(1);
        det.wd_overflow <= 1'b0;
        rdc(8'h28, 32'h8);
        rdc(8'h10, 32'h20);
        chk(err_oe, 1'b0);
        apb(1'b1, 8'h00, 32'h1);
        rdc(8'h28, 32'h8);
        apb(1'b1, 8'h00, 32'h4);
        rdc(8'h28, 32'h4);
        // Undervoltage mid-run, then a late rail holds the power-on state
        det.supply_uvlo <= 1'b1;
        tick(3);
        chk(err_n, 1'b0);
        chk(channel_drive, 12'h000);
        det.supply_uvlo <= 1'b0;
        det.rails_good <= 1'b0;
        rdc(8'h28, 32'h1);
        det.rails_good <= 1'b1;
        tick(2);
        rdc(8'h28, 32'h4);
        rdc(8'h10, 32'h1001);
        apb(1'b1, 8'h00, 32'h2);
        apb(1'b1, 8'h04, 32'hF);
        apb(1'b1, 8'h00, 32'h10);
        // Start strobe and captured channels are only settled between edges
        @(negedge pclk);
        chk(ss_scan_go, 1'b1);
        @(negedge pclk);
        chk(scan_channels, 12'hFF0);
        rdc(8'h00, 32'h0);
        rdc(8'h10, 32'h0);
        det.ss_below <= 12'h031;
        det.ss_done <= 1'b1;
        tick(1);
        det.ss_done <= 1'b0;
        rdc(8'h1C, 32'h30);
        rdc(8'h10, 32'h1D00);
        apb(1'b1, 8'h00, 32'h1);
        // Ready is still set here, so the start must visibly clear it
        apb(1'b1, 8'h00, 32'h8);
        @(negedge pclk);
        chk(inv_scan_go, 1'b1);
        rdc(8'h10, 32'h0);
        det.inv_fail <= 12'h101;
        det.inv_done <= 1'b1;
        tick(1);
        det.inv_done <= 1'b0;
        rdc(8'h1C, 32'h100);
        rdc(8'h10, 32'h1D00);
        tick(500);
        chk(err_n, 1'b1);
        // Clear and auto result in one cycle: the new result wins
        apb(1'b1, 8'h00, 32'h21);
        det.auto_below <= 12'h0F3;
        det.auto_valid <= 1'b1;
        tick(1);
        det.auto_valid <= 1'b0;
        rdc(8'h1C, 32'h3);
        chk(err_n, 1'b0);
        apb(1'b1, 8'h00, 32'h1);
        apb(1'b1, 8'h08, 32'hFE);
        det.open_window_ok <= 12'hFFB;
        det.open_det <= 12'h0FF;
        tick(2);
        det.open_det <= 12'h000;
        rdc(8'h14, 32'hA);
        apb(1'b0, 8'h3C, 32'h0);
        chk(rd, 32'h0);
        chk(se, 1'b1);
        give_verdict;
    end
endmodule
`default_nettype wire
